// file: hdl/awt_watchdog.sv
// Watchdog core: registers, lock, down-counter, interrupt and reset output.
// Assumes a no-wait-state two-phase bus and a count clock sampled on clk_sys.
//
// Notes on behaviour
// [RQ1] Control register clears on reset
// [RQ2] Write lock comes up unlocked
// [RQ3] Counter holds all ones until enabled
// [RQ4] Enable loads on next tick, then decrements
// [RQ5] Count only on enabled count clock edges
// [RQ6] Zero sets interrupt and reloads counter
// [RQ7] Clear write drops interrupt and reloads
// [RQ8] Pending at next zero asserts reset output
// [RQ9] Reset output stops the counter
// [RQ10] Irq set on tick, cleared at once
// [RQ11] Reload write restarts running counter immediately
// [RQ12] Reload write leaves interrupt pending
// [RQ13] Disable freezes, re-enable reloads first
// [RQ14] Interval is reload plus one ticks
// [RQ15] Zero reload interrupts on next tick
// [RQ16] Key unlocks, other values lock
// [RQ17] Lock reads back lock status only
// [RQ18] Control bit1 reset enable, bit0 enable
// [RQ19] Raw status shows zero-reached event
// [RQ20] Masked status equals raw AND enable
// [RQ21] Value register reads live counter
// [RQ22] Software programs reload before enabling
// [RQ23] Software relocks after changing registers
// [RQ24] Domain reset clears counter side state
// [RQ25] Count clock no faster, edges aligned
// [RQ26] Word decode from address bits 11:2
// [RQ27] Reserved and unmapped read zero
// [RQ28] Reset output holds until reset
`default_nettype none

module awt_watchdog (
	// Clock and resets
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        wd_domain_reset_n,
	// Count clock
	input  wire logic        wd_count_clock,
	input  wire logic        wd_count_clock_enable,
	// Register bus
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:2] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	// Event outputs
	output logic             timeout_irq,
	output logic             timeout_reset_out
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	awt_reg_if                          regs ();
	logic                               tick;
	logic [awt_pkg::DATA_W-1:0]         reload;
	logic [awt_pkg::DATA_W-1:0]         count;
	logic [awt_pkg::CTRL_W-1:0]         ctrl;
	logic                               locked;
	logic                               raw;
	awt_pkg::awt_state_t                state;
	awt_pkg::awt_state_t                next_state;
	logic [awt_pkg::DATA_W-1:0]         next_count;
	logic [awt_pkg::CTRL_W-1:0]         next_ctrl;
	logic                               next_raw;
	logic                               next_rst_out;
	logic                               reload_w;
	logic                               ctrl_w;
	logic                               clear_w;
	logic                               zero_hit;
	logic                               running;

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	// Bus decode into one-cycle strobes
	awt_apb_decode u_decode (
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr), // see [RQ26]
		.pwdata  (pwdata),
		.regs    (regs.dec)
	);

	// Enabled count clock edges
	awt_tick_gen u_tick (
		.clk_sys               (clk_sys),
		.rst_b                 (rst_b),
		.wd_count_clock        (wd_count_clock),
		.wd_count_clock_enable (wd_count_clock_enable),
		.tick                  (tick)
	);

	// ----------------------------------------
	// Write qualification
	// ----------------------------------------
	// While locked only the lock register accepts writes
	assign reload_w = regs.wr_reload && !locked; // see [RQ16]
	assign ctrl_w   = regs.wr_ctrl && !locked;   // see [RQ16]
	assign clear_w  = regs.wr_clear && !locked;  // see [RQ16]
	assign running  = (state == awt_pkg::ST_RUN) && ctrl[awt_pkg::BIT_IRQ_COUNT_ENABLE];
	assign zero_hit = tick && running && (count == awt_pkg::COUNT_ZERO); // see [RQ14]

	// ----------------------------------------
	// Lock register
	// ----------------------------------------
	// Any value other than the key relocks; comparison is on the full word
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			locked <= 1'b0; // see [RQ2]
		else if (regs.wr_lock)
			locked <= (regs.wdata != awt_pkg::LOCK_KEY); // see [RQ16]
	end

	// ----------------------------------------
	// Reload and control registers
	// ----------------------------------------
	// Reload value is kept by the bus reset only
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			reload <= awt_pkg::RELOAD_RST;
		else if (reload_w)
			reload <= regs.wdata;
	end

	// Upper control bits are reserved and dropped on write
	assign next_ctrl = ctrl_w ? regs.wdata[awt_pkg::CTRL_W-1:0] : ctrl; // see [RQ18]

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			ctrl <= awt_pkg::CTRL_RST; // see [RQ1]
		else
			ctrl <= next_ctrl;
	end

	// ----------------------------------------
	// Counter state machine
	// ----------------------------------------
	// In the run state bus-side reloads act in the cycle of the write, not on the next tick,
	// so a reload write and a tick in one cycle leave the written value, except a tick that times out into the halt state.
	always_comb
	begin
		next_state   = state;
		next_count   = count;
		next_rst_out = timeout_reset_out;
		case (state)
			awt_pkg::ST_IDLE:
			begin
				// Frozen; first enabled tick loads rather than decrements
				if (tick && ctrl[awt_pkg::BIT_IRQ_COUNT_ENABLE])
				begin
					next_count = reload; // see [RQ4] see [RQ13]
					next_state = awt_pkg::ST_RUN;
				end
			end
			awt_pkg::ST_RUN:
			begin
				if (!ctrl[awt_pkg::BIT_IRQ_COUNT_ENABLE])
					next_state = awt_pkg::ST_IDLE; // see [RQ13]
				else
				begin
					if (zero_hit)
					begin
						// Clear arriving with the zero counts as in time
						if (raw && !clear_w && ctrl[awt_pkg::BIT_RESET_OUT_ENABLE])
						begin
							next_rst_out = 1'b1;           // see [RQ8]
							next_state   = awt_pkg::ST_HALT; // see [RQ9]
						end
						else
							next_count = reload; // see [RQ6] see [RQ15]
					end
					else if (tick)
						next_count = count - awt_pkg::COUNT_ONE; // see [RQ4]
					if (next_state == awt_pkg::ST_RUN)
					begin
						if (reload_w)
							next_count = regs.wdata; // see [RQ11]
						else if (clear_w)
							next_count = reload; // see [RQ7]
					end
				end
			end
			awt_pkg::ST_HALT:
			begin
				// Stays put until one of the resets
				next_rst_out = 1'b1; // see [RQ28]
			end
			default:
			begin
				next_state = awt_pkg::ST_IDLE;
			end
		endcase
	end

	// Raw status: a zero event in the cycle of a clear write still sets it
	always_comb
	begin
		next_raw = raw;
		if (clear_w)
			next_raw = 1'b0; // see [RQ7] see [RQ12]
		if (zero_hit)
			next_raw = 1'b1; // see [RQ6] see [RQ19]
	end

	// Counter side state; domain reset is a synchronous clear
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state             <= awt_pkg::ST_IDLE;
			count             <= awt_pkg::COUNT_RST; // see [RQ3]
			raw               <= 1'b0;
			timeout_reset_out <= 1'b0;
		end
		else if (!wd_domain_reset_n)
		begin
			state             <= awt_pkg::ST_IDLE; // see [RQ24]
			count             <= awt_pkg::COUNT_RST;
			raw               <= 1'b0;
			timeout_reset_out <= 1'b0;
		end
		else
		begin
			state             <= next_state;
			count             <= next_count;
			raw               <= next_raw;
			timeout_reset_out <= next_rst_out;
		end
	end

	// ----------------------------------------
	// Interrupt output
	// ----------------------------------------
	// Built from next values so the flop equals raw AND enable every cycle
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			timeout_irq <= 1'b0;
		else if (!wd_domain_reset_n)
			timeout_irq <= 1'b0;
		else
			timeout_irq <= next_raw && next_ctrl[awt_pkg::BIT_IRQ_COUNT_ENABLE]; // see [RQ10] see [RQ20]
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Captured in the setup phase; holds otherwise to save toggling
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			prdata <= awt_pkg::RD_ZERO;
		else if (regs.rd_setup)
		begin
			case (regs.rd_index)
				awt_pkg::OFF_RELOAD[11:2]: prdata <= reload;
				awt_pkg::OFF_VALUE[11:2]:  prdata <= count; // see [RQ21]
				awt_pkg::OFF_CTRL[11:2]:   prdata <= {30'h0, ctrl};
				awt_pkg::OFF_RAW[11:2]:    prdata <= {31'h0, raw}; // see [RQ19]
				awt_pkg::OFF_MASKED[11:2]: prdata <= {31'h0, raw && ctrl[awt_pkg::BIT_IRQ_COUNT_ENABLE]};
				awt_pkg::OFF_LOCK[11:2]:   prdata <= {31'h0, locked}; // see [RQ17]
				default:                   prdata <= awt_pkg::RD_ZERO; // see [RQ27]
			endcase
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b || !wd_domain_reset_n);

	a_enable_load: assert property ( // see [RQ4]
		tick && (state == awt_pkg::ST_IDLE) && ctrl[awt_pkg::BIT_IRQ_COUNT_ENABLE]
		|=> (state == awt_pkg::ST_RUN) && (count == $past(reload)))
		else $error("enable did not load counter from reload");

	a_count_decrement: assert property ( // see [RQ4]
		tick && running && (count != awt_pkg::COUNT_ZERO) && !reload_w && !clear_w
		|=> count == $past(count) - awt_pkg::COUNT_ONE)
		else $error("counter did not decrement by one");

	a_zero_raises: assert property ( // see [RQ6]
		zero_hit && !(raw && ctrl[awt_pkg::BIT_RESET_OUT_ENABLE]) && !reload_w
		|=> raw && (count == $past(reload)) && (timeout_irq == ctrl[awt_pkg::BIT_IRQ_COUNT_ENABLE]))
		else $error("zero did not raise interrupt and reload");

	a_reset_assert: assert property ( // see [RQ8]
		zero_hit && raw && ctrl[awt_pkg::BIT_RESET_OUT_ENABLE] && !clear_w
		|=> timeout_reset_out ##1 timeout_reset_out)
		else $error("pending interrupt at zero gave no reset");

	a_reset_masked: assert property ( // see [RQ8]
		zero_hit && !ctrl[awt_pkg::BIT_RESET_OUT_ENABLE] && !timeout_reset_out
		|=> !timeout_reset_out)
		else $error("reset output asserted while disabled");

	a_halt_stops: assert property ( // see [RQ9]
		timeout_reset_out |=> timeout_reset_out && $stable(count))
		else $error("counter moved or reset dropped after timeout");

	a_irq_masked: assert property ( // see [RQ20]
		timeout_irq == (raw && ctrl[awt_pkg::BIT_IRQ_COUNT_ENABLE]))
		else $error("interrupt output differs from masked status");

	a_clear_drops: assert property ( // see [RQ10]
		clear_w && !zero_hit |=> !timeout_irq && !raw)
		else $error("clear write did not drop interrupt next cycle");

	a_disable_freeze: assert property ( // see [RQ13]
		!ctrl[awt_pkg::BIT_IRQ_COUNT_ENABLE] && !$past(ctrl[awt_pkg::BIT_IRQ_COUNT_ENABLE]) |=> $stable(count))
		else $error("counter moved while disabled");

	a_lock_read: assert property ( // see [RQ17]
		regs.rd_setup && (regs.rd_index == awt_pkg::OFF_LOCK[11:2])
		|=> prdata == {31'h0, $past(locked)})
		else $error("lock read did not return lock status");

	a_locked_ctrl: assert property ( // see [RQ16]
		locked && regs.wr_ctrl |=> ctrl == $past(ctrl))
		else $error("control changed while locked");

	// Bus-side restarts act at the write edge, not at the next tick
	a_reload_now: assert property ( // see [RQ11]
		reload_w && running
		&& !(zero_hit && raw && ctrl[awt_pkg::BIT_RESET_OUT_ENABLE] && !clear_w)
		|=> count == $past(regs.wdata))
		else $error("reload write did not restart the counter");

	a_clear_reload: assert property ( // see [RQ7]
		clear_w && !reload_w && running |=> count == $past(reload))
		else $error("clear write did not reload the counter");

	c_zero_event: cover property (zero_hit);
	c_reset_rise: cover property (!timeout_reset_out ##1 timeout_reset_out);
	c_clear_irq: cover property (timeout_irq ##1 clear_w ##1 !timeout_irq);
	c_unlock: cover property (locked ##1 !locked);

endmodule : awt_watchdog

`default_nettype wire

// file: include/awt_pkg.sv
// Shared constants and types for the bus-slave watchdog timer.
// Assumes word-aligned 32-bit register accesses decoded from address bits 11:2.
`default_nettype none

package awt_pkg;

	// ----------------------------------------
	// Data path
	// ----------------------------------------
	localparam int          DATA_W     = 32;
	localparam int          IDX_W      = 10;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [11:0] OFF_RELOAD = 12'h000;
	localparam logic [11:0] OFF_VALUE  = 12'h004;
	localparam logic [11:0] OFF_CTRL   = 12'h008;
	localparam logic [11:0] OFF_CLEAR  = 12'h00c;
	localparam logic [11:0] OFF_RAW    = 12'h010;
	localparam logic [11:0] OFF_MASKED = 12'h014;
	localparam logic [11:0] OFF_LOCK   = 12'hc00;

	// ----------------------------------------
	// Field positions, reset values, keys
	// ----------------------------------------
	localparam int          CTRL_W       = 2;
	localparam int          BIT_IRQ_COUNT_ENABLE    = 0;
	localparam int          BIT_RESET_OUT_ENABLE    = 1;
	localparam logic [1:0]  CTRL_RST     = 2'h0;
	localparam logic [31:0] RELOAD_RST   = 32'h0fffffff;
	localparam logic [31:0] COUNT_RST    = 32'hffffffff;
	localparam logic [31:0] COUNT_ONE    = 32'h00000001;
	localparam logic [31:0] COUNT_ZERO   = 32'h00000000;
	localparam logic [31:0] LOCK_KEY     = 32'h1acce551;
	localparam logic [31:0] RD_ZERO      = 32'h00000000;

	// ----------------------------------------
	// Counter states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RUN  = 3'b010,
		ST_HALT = 3'b100
	} awt_state_t;

endpackage : awt_pkg

`default_nettype wire

// file: include/awt_reg_if.sv
// Decoded register strobes passed from the bus decoder to the watchdog core.
// Assumes both ends run on the one system clock.
`default_nettype none

interface awt_reg_if;
	logic                            wr_reload;
	logic                            wr_ctrl;
	logic                            wr_clear;
	logic                            wr_lock;
	logic                            rd_setup;
	logic [awt_pkg::IDX_W-1:0]       rd_index;
	logic [awt_pkg::DATA_W-1:0]      wdata;

	modport dec  (output wr_reload, wr_ctrl, wr_clear, wr_lock, rd_setup, rd_index, wdata);
	modport core (input  wr_reload, wr_ctrl, wr_clear, wr_lock, rd_setup, rd_index, wdata);
endinterface : awt_reg_if

`default_nettype wire

// file: hdl/awt_apb_decode.sv
// Bus decoder: turns select, enable and direction into per-register strobes.
// Assumes a two-phase bus with no wait states; writes act in the access phase.
`default_nettype none

module awt_apb_decode (
	// Bus side
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:2] paddr,
	input  wire logic [31:0] pwdata,
	// Core side
	awt_reg_if.dec           regs
);
	logic wr_access;

	// Write strobes last one cycle, in the access phase only
	assign wr_access      = psel && penable && pwrite;
	assign regs.wr_reload = wr_access && (paddr == awt_pkg::OFF_RELOAD[11:2]);
	assign regs.wr_ctrl   = wr_access && (paddr == awt_pkg::OFF_CTRL[11:2]);
	assign regs.wr_clear  = wr_access && (paddr == awt_pkg::OFF_CLEAR[11:2]);
	assign regs.wr_lock   = wr_access && (paddr == awt_pkg::OFF_LOCK[11:2]);
	// Reads are captured in the setup phase so read data is a flop in access
	assign regs.rd_setup  = psel && !penable && !pwrite;
	assign regs.rd_index  = paddr;
	assign regs.wdata     = pwdata;
endmodule : awt_apb_decode

`default_nettype wire

// file: hdl/awt_tick_gen.sv
// Enabled-edge detector for the watchdog count clock.
// Assumes the count clock is synchronous and at most half the system clock rate.
`default_nettype none

module awt_tick_gen (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_b,
	// Count clock
	input  wire logic wd_count_clock,
	input  wire logic wd_count_clock_enable,
	// One-cycle tick per enabled rising edge
	output logic      tick
);
	logic clk_prev;

	// Previous level of the count clock
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			clk_prev <= 1'b0;
		else
			clk_prev <= wd_count_clock;
	end

	// Edges without the enable do not count
	assign tick = wd_count_clock && !clk_prev && wd_count_clock_enable; // see [RQ5]
endmodule : awt_tick_gen

`default_nettype wire

// file: verif/awt_bridge_model.sv
// Bus bridge and count clock source model standing in front of the watchdog.
// Assumes the bench calls its bus task from one process at a time.
`default_nettype none

module awt_bridge_model (
	// Clock
	input  wire logic        clk_sys,
	// Register bus
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:2] paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	// Count clock
	output logic             wd_count_clock
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle bus at time zero
	initial
	begin
		psel           = 1'b0;
		penable        = 1'b0;
		pwrite         = 1'b0;
		paddr          = 10'h000;
		pwdata         = 32'h00000000;
		wd_count_clock = 1'b0;
	end

	// Half the bus rate, edges on bus edges; the fastest the sampler accepts
	always @(posedge clk_sys)
		wd_count_clock <= ~wd_count_clock;

	// One setup and one access phase; read data taken at the access edge
	task automatic access(input logic wr, input logic [11:0] addr, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_sys);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= addr[11:2];
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		q = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
		// Released lines show no stale value
		paddr   <= ~addr[11:2];
		pwdata  <= ~d;
	endtask : access

endmodule : awt_bridge_model

`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the watchdog: reset values, lock, countdown, reset output.
// Assumes the bridge model drives the bus and the count clock.
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk_sys;
	logic        rst_b;
	logic        wd_domain_reset_n;
	logic        wd_count_clock;
	logic        wd_count_clock_enable;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:2] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        timeout_irq;
	logic        timeout_reset_out;
	logic [31:0] seed = 32'h000113f1;
	int          failures = 0;
	int          n_compared = 0;
	int          ticks = 0;
	int          t0;
	int          n;
	logic        cc_q = 1'b0;
	logic [31:0] r;
	logic [31:0] v;

	awt_bridge_model awt_bridge_model_i (.clk_sys(clk_sys), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.wd_count_clock(wd_count_clock));
	awt_watchdog awt_watchdog_i (.clk_sys(clk_sys), .rst_b(rst_b),
		.wd_domain_reset_n(wd_domain_reset_n), .wd_count_clock(wd_count_clock),
		.wd_count_clock_enable(wd_count_clock_enable), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.timeout_irq(timeout_irq), .timeout_reset_out(timeout_reset_out));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			failures++;
		end
	endtask : cmp32

	task automatic cmp_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp)
		begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			failures++;
		end
	endtask : cmp_bit

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		awt_bridge_model_i.access(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		awt_bridge_model_i.access(1'b0, a, 32'h00000000, q);
		cmp32(q, exp);
	endtask : rd

	// Start the tick count once the last edge's updates have landed
	task automatic mark();
		#1;
		t0 = ticks;
	endtask : mark

	// Bounded wait for irq (sel 0) or reset output (sel 1); ticks since mark
	task automatic wait_flag(input logic sel, output int cnt);
		for (int i = 0; i < 300; i++)
		begin
			@(posedge clk_sys);
			#1;
			if ((sel ? timeout_reset_out : timeout_irq) === 1'b1)
				break;
		end
		cnt = ticks - t0;
	endtask : wait_flag

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	// Clock, random count enable and the bench's own count of enabled edges
	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys)
	begin
		wd_count_clock_enable <= (xs() & 32'h3) != 32'h0;
		if (wd_count_clock && !cc_q && wd_count_clock_enable)
			ticks <= ticks + 1;
		cc_q <= wd_count_clock;
	end

	// Cut a hang short well beyond the longest expected run
	initial
	begin
		#1000000;
		failures++;
		wrap_up();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		rst_b = 1'b0;
		wd_domain_reset_n = 1'b0;
		wd_count_clock_enable = 1'b0;
		repeat (4) @(posedge clk_sys);
		rst_b <= 1'b1;
		wd_domain_reset_n <= 1'b1;
		// Reset values, including an unmapped word
		rd(awt_pkg::OFF_RELOAD, awt_pkg::RELOAD_RST);
		rd(awt_pkg::OFF_VALUE, awt_pkg::COUNT_RST);
		rd(awt_pkg::OFF_CTRL, 32'h00000000);
		rd(awt_pkg::OFF_RAW, 32'h00000000);
		rd(awt_pkg::OFF_MASKED, 32'h00000000);
		rd(awt_pkg::OFF_LOCK, 32'h00000000);
		rd(12'h018, 32'h00000000);
		$display("test reset values done");
		// Locked writes are dropped, the key unlocks
		r = xs() | 32'h00000002;
		wr(awt_pkg::OFF_LOCK, r);
		rd(awt_pkg::OFF_LOCK, 32'h00000001);
		wr(awt_pkg::OFF_CTRL, 32'h00000001);
		rd(awt_pkg::OFF_CTRL, 32'h00000000);
		wr(awt_pkg::OFF_LOCK, awt_pkg::LOCK_KEY);
		rd(awt_pkg::OFF_LOCK, 32'h00000000);
		$display("test lock done");
		// Countdown: load on first tick, then reload+1 ticks to the interrupt
		r = 32'h3 + (xs() % 6);
		wr(awt_pkg::OFF_RELOAD, r);
		wr(awt_pkg::OFF_CTRL, 32'hfffffffd);
		mark();
		wait_flag(1'b0, n);
		cmp32(n, r + 2);
		rd(awt_pkg::OFF_CTRL, 32'h00000001);
		rd(awt_pkg::OFF_RAW, 32'h00000001);
		rd(awt_pkg::OFF_MASKED, 32'h00000001);
		$display("test countdown done");
		// Reload keeps the interrupt; disable freezes; clear drops it at once
		r = 32'h8 + (xs() % 8); // Long enough that no zero meets the clear
		wr(awt_pkg::OFF_RELOAD, r);
		rd(awt_pkg::OFF_RAW, 32'h00000001);
		wr(awt_pkg::OFF_CTRL, 32'h00000000);
		#1;
		cmp_bit(timeout_irq, 1'b0);
		awt_bridge_model_i.access(1'b0, awt_pkg::OFF_VALUE, 32'h0, v);
		repeat (12) @(posedge clk_sys);
		rd(awt_pkg::OFF_VALUE, v);
		rd(awt_pkg::OFF_RAW, 32'h00000001);
		wr(awt_pkg::OFF_CTRL, 32'h00000001);
		#1;
		cmp_bit(timeout_irq, 1'b1);
		repeat (8) @(posedge clk_sys);
		wr(awt_pkg::OFF_CLEAR, xs());
		mark();
		cmp_bit(timeout_irq, 1'b0);
		wait_flag(1'b0, n);
		cmp32(n, r + 1);
		wr(awt_pkg::OFF_CLEAR, xs());
		wr(awt_pkg::OFF_RELOAD, 32'h00000000);
		mark();
		wait_flag(1'b0, n);
		cmp32(n, 32'h1);
		$display("test interrupt done");
		// Pending interrupt at the next zero asserts the reset output
		r = 32'h3 + (xs() % 6);
		wr(awt_pkg::OFF_RELOAD, r);
		mark();
		wr(awt_pkg::OFF_CTRL, 32'h00000003);
		wait_flag(1'b1, n);
		cmp32(n, r + 1);
		rd(awt_pkg::OFF_VALUE, 32'h00000000);
		wr(awt_pkg::OFF_CLEAR, xs());
		repeat (10) @(posedge clk_sys);
		rd(awt_pkg::OFF_VALUE, 32'h00000000);
		cmp_bit(timeout_reset_out, 1'b1);
		// Counter-side reset clears the reset output and raw status but not the control register
		@(posedge clk_sys);
		wd_domain_reset_n <= 1'b0;
		@(posedge clk_sys);
		wd_domain_reset_n <= 1'b1;
		#1;
		cmp_bit(timeout_reset_out, 1'b0);
		rd(awt_pkg::OFF_CTRL, 32'h00000003);
		rd(awt_pkg::OFF_RAW, 32'h00000000);
		$display("test reset output done");
		// Relock, then a bus reset in mid-run brings back the reset state
		wr(awt_pkg::OFF_LOCK, awt_pkg::LOCK_KEY ^ xs() | 32'h1);
		rd(awt_pkg::OFF_LOCK, 32'h00000001);
		@(posedge clk_sys);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		rd(awt_pkg::OFF_LOCK, 32'h00000000);
		rd(awt_pkg::OFF_CTRL, 32'h00000000);
		rd(awt_pkg::OFF_VALUE, awt_pkg::COUNT_RST);
		$display("test bus reset done");
		wrap_up();
	end

endmodule : tb_top

`default_nettype wire
